// ===== core/qsr_defines.svh
// Constants of the questionable status bank: map, fields, resets.
// Assumes inclusion by bare name; definitions only.
`ifndef QSR_DEFINES_SVH
`define QSR_DEFINES_SVH

// ===========================================================
// Groups
`define QSR_NGRP        10
`define QSR_GRP_COVL    4'h0
`define QSR_GRP_ADC     4'h1
`define QSR_GRP_GOVL    4'h2
`define QSR_GRP_TEMP    4'h3
`define QSR_GRP_PSUP    4'h4
`define QSR_GRP_POVL    4'h5
`define QSR_GRP_ALGN    4'h6
`define QSR_GRP_LIM     4'h7
`define QSR_GRP_MAR     4'h8
`define QSR_GRP_IMP     4'h9

// ===========================================================
// Source layout and existing sources per group
`define QSR_COVL_WARN_LSB  8
`define QSR_COVL_EXTTRIG   16
`define QSR_COVL_TRIGOUT   17
`define QSR_TEMP_WARN      0
`define QSR_TEMP_ERR       1
`define QSR_MASK_COVL   32'h0003_FFFF
`define QSR_MASK_ADC    32'hFFFF_FFFF
`define QSR_MASK_GOVL   32'h0000_0003
`define QSR_MASK_TEMP   32'h0000_0003
`define QSR_MASK_PSUP   32'h0000_00FF
`define QSR_MASK_POVL   32'h0000_00FF
`define QSR_MASK_ALGN   32'h3FFF_FFFF
`define QSR_MASK_MEASUREMENT_SOURCE   32'h0000_00FF

// ===========================================================
// Register map (byte addresses)
`define QSR_GRP_SPAN    12'h140
`define QSR_GRP_MSB     8
`define QSR_GRP_LSB     5
`define QSR_WRD_MSB     4
`define QSR_WRD_LSB     2
`define QSR_WRD_COND    3'h0
`define QSR_WRD_EVT     3'h1
`define QSR_WRD_ENA     3'h2
`define QSR_WRD_PTR     3'h3
`define QSR_WRD_NTR     3'h4
`define QSR_WRD_SEL     3'h5
`define QSR_ADDR_SUM    12'h180
`define QSR_ADDR_ISTAT  12'h184
`define QSR_ADDR_IMASK  12'h188
`define QSR_ADDR_PRESET 12'h18C
`define QSR_ADDR_SUMENA 12'h190
`define QSR_ADDR_LSEL   12'h194
`define QSR_ADDR_LPOP   12'h198
`define QSR_ADDR_VSEL   12'h19C
`define QSR_ADDR_VIEW   12'h1A0

// ===========================================================
// Fields
`define QSR_SEL_PART_MSB 1
`define QSR_SEL_ALL      4
`define QSR_PART_ENA     2'h1
`define QSR_PART_PTR     2'h2
`define QSR_PART_NTR     2'h3
`define QSR_LSEL_EVT     4
`define QSR_LIST_VALID   31
`define QSR_IDX_W        5
`define QSR_VSEL_GRP_LSB 8
`define QSR_VIEW_ENA     0
`define QSR_VIEW_EVT     1
`define QSR_VIEW_COND    2
`define QSR_PRESET_GO    0

// ===========================================================
// Reset values
`define QSR_RST_ZERO     32'h0000_0000
`define QSR_RST_ONES     32'hFFFF_FFFF

`endif

// ===== core/qsr_group_cell.sv
// One questionable group: synchronised condition, filters, events.
// Assumes conditions arrive asynchronous; strobes come from the bank.
`timescale 1ns/1ps
`include "qsr_defines.svh"

module qsr_group_cell (
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   input  qsr_pkg::qsr_word_t condRaw,
   input  qsr_pkg::qsr_word_t validMask,
   input  wire logic        wrEna,
   input  wire logic        wrPtr,
   input  wire logic        wrNtr,
   input  qsr_pkg::qsr_word_t wrData,
   input  qsr_pkg::qsr_word_t evtClr,
   input  wire logic        preset,
   output qsr_pkg::qsr_grp_t grp,
   output logic             summary
);

   qsr_pkg::qsr_cell_st_t q;
   qsr_pkg::qsr_cell_st_t d;
   qsr_pkg::qsr_word_t    rise;
   qsr_pkg::qsr_word_t    fall;

   // ===========================================================
   // Next state
   always_comb begin
      d       = q;
      d.sync1 = condRaw;
      d.sync2 = q.sync1;
      d.prev  = q.sync2;
      rise    = q.sync2 & ~q.prev & q.ptr;
      fall    = ~q.sync2 & q.prev & q.ntr;
      // New edges win over the read clear
      d.evt   = ((q.evt & ~evtClr) | rise | fall) & validMask;
      if (wrEna) begin
         d.ena = wrData & validMask;
      end
      if (wrPtr) begin
         d.ptr = wrData & validMask;
      end
      if (wrNtr) begin
         d.ntr = wrData & validMask;
      end
      if (preset) begin
         d.ptr = validMask;
         d.ntr = `QSR_RST_ZERO;
         d.evt = `QSR_RST_ZERO;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         q       <= '0;
         q.ptr   <= `QSR_RST_ONES;
      end else begin
         q <= d;
      end
   end

   // Condition is the live level, never cleared by a read
   assign grp.cond = q.sync2 & validMask;
   assign grp.evt  = q.evt;
   assign grp.ena  = q.ena;
   assign grp.ptr  = q.ptr & validMask;
   assign grp.ntr  = q.ntr;
   assign summary  = |(q.evt & q.ena);

   // ===========================================================
   // Checks
   a_rise_sets_event: assert property (@(posedge core_clk)
      disable iff (!rst_n) (!preset && rise != '0) |=>
      ((grp.evt & $past(rise & validMask)) == $past(rise & validMask)))
      else $error("rising edge lost its event");

   a_fall_sets_event: assert property (@(posedge core_clk)
      disable iff (!rst_n) (!preset && fall != '0) |=>
      ((grp.evt & $past(fall & validMask)) == $past(fall & validMask)))
      else $error("falling edge lost its event");

   a_preset_filters: assert property (@(posedge core_clk)
      disable iff (!rst_n) preset |=>
      (grp.ptr == validMask && grp.ntr == '0 && grp.evt == '0))
      else $error("preset left filters or events");

   a_event_holds: assert property (@(posedge core_clk)
      disable iff (!rst_n) (!preset && evtClr == '0) |=>
      ((grp.evt & $past(grp.evt)) == $past(grp.evt)))
      else $error("event dropped without a read");

endmodule : qsr_group_cell

// ===== core/qsr_pkg.sv
// Types of the questionable status bank.
// Assumes qsr_defines.svh is on the include path.
`include "qsr_defines.svh"

package qsr_pkg;

   typedef logic [31:0] qsr_word_t;

   // ===========================================================
   // Live conditions, one word per group
   typedef struct packed {
      qsr_word_t channelOverload;
      qsr_word_t converterClip;
      qsr_word_t generatorOverload;
      qsr_word_t thermal;
      qsr_word_t probeSupply;
      qsr_word_t probeOverload;
      qsr_word_t missingAlignment;
      qsr_word_t measLimit;
      qsr_word_t measMargin;
      qsr_word_t measImprecise;
   } qsr_cond_t;

   typedef struct packed {
      qsr_word_t cond;
      qsr_word_t evt;
      qsr_word_t ena;
      qsr_word_t ptr;
      qsr_word_t ntr;
   } qsr_grp_t;

   typedef struct packed {
      logic [11:0] paddr;
      logic        pwrite;
      qsr_word_t   pwdata;
      logic        psel;
      logic        penable;
   } qsr_apb_req_t;

   typedef struct packed {
      qsr_word_t sync1;
      qsr_word_t sync2;
      qsr_word_t prev;
      qsr_word_t evt;
      qsr_word_t ena;
      qsr_word_t ptr;
      qsr_word_t ntr;
   } qsr_cell_st_t;

   typedef struct packed {
      qsr_word_t                 prdata;
      logic [`QSR_NGRP-1:0]      sumEna;
      logic [`QSR_NGRP-1:0]      irqStat;
      logic [`QSR_NGRP-1:0]      irqMask;
      logic [`QSR_NGRP-1:0]      sumPrev;
      qsr_word_t                 listSnap;
      logic [11:0]               viewSel;
   } qsr_top_st_t;

endpackage : qsr_pkg

// ===== core/qsr_status_bank.sv
// Questionable status bank: ten groups behind an APB slave.
// Assumes a zero-wait APB master on core_clk and asynchronous
// condition inputs from the measurement and analog logic.
//
// Operation
// - Condition reads show live flags and never alter them.
// - Event read returns latched bits and then clears the bits it returned.
// - Event bits stay set until an event read, event list query or preset of their group.
// - Event or enable queries yield a list of set sources.
// - Each group accepts a NONE selector and an ALL selector.
// - Thermal group has a warning source for a hot unit.
// - Thermal group has an error source before automatic shutdown.
// - Converter group: channel and probe positive and negative clipping.
// - Overload group: channels, channel warnings, trigger in, trigger out.
// - Conditions include limit, margin, imprecision per measurement.
// - Per-source views and group bits share one flag.
// - Enabled set event raises the group summary bit upward.
// - Rising filter bit makes a 0 to 1 condition set event.
// - Falling filter bit makes a 1 to 0 condition set event.
// - Preset sets rising filters, clears falling, events, top enables.
//
// Design decisions made here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "qsr_defines.svh"

module qsr_status_bank (
   input  wire logic             core_clk,
   input  wire logic             rst_n,
   input  qsr_pkg::qsr_apb_req_t apbReq,
   output logic [31:0]           prdata,
   output logic                  pready,
   output logic                  pslverr,
   input  qsr_pkg::qsr_cond_t    condIn,
   output logic                  questSummary,
   output logic                  irq
);

   qsr_pkg::qsr_top_st_t q;
   qsr_pkg::qsr_top_st_t d;

   qsr_pkg::qsr_grp_t    grpView [`QSR_NGRP];
   qsr_pkg::qsr_word_t   condArr [`QSR_NGRP];
   qsr_pkg::qsr_word_t   maskArr [`QSR_NGRP];
   qsr_pkg::qsr_word_t   clrArr  [`QSR_NGRP];
   logic [`QSR_NGRP-1:0] sumVec;
   logic [`QSR_NGRP-1:0] wrEnaVec;
   logic [`QSR_NGRP-1:0] wrPtrVec;
   logic [`QSR_NGRP-1:0] wrNtrVec;
   logic                 setupPh;
   logic                 accessPh;
   logic                 wrAcc;
   logic                 rdAcc;
   logic                 grpHit;
   logic [3:0]           grpIdx;
   logic [2:0]           wordIdx;
   logic                 mapped;
   logic [1:0]           selPart;
   logic                 presetGo;
   logic [3:0]           listGrp;
   logic                 listGrpOk;
   logic [3:0]           viewGrp;
   logic                 viewGrpOk;
   logic [`QSR_IDX_W-1:0] viewIdx;
   logic [`QSR_IDX_W-1:0] popIdx;
   logic                 popValid;
   qsr_pkg::qsr_word_t   rdVal;
   qsr_pkg::qsr_word_t   selData;

   // ===========================================================
   // Source wiring
   // Clipping words: channel pos, channel neg, probe pos, probe neg
   // bytes; overload word: channels, warnings, trigger in and out.
   always_comb begin
      condArr[`QSR_GRP_COVL] = condIn.channelOverload;
      condArr[`QSR_GRP_ADC]  = condIn.converterClip;
      condArr[`QSR_GRP_GOVL] = condIn.generatorOverload;
      condArr[`QSR_GRP_TEMP] = condIn.thermal;
      condArr[`QSR_GRP_PSUP] = condIn.probeSupply;
      condArr[`QSR_GRP_POVL] = condIn.probeOverload;
      condArr[`QSR_GRP_ALGN] = condIn.missingAlignment;
      condArr[`QSR_GRP_LIM]  = condIn.measLimit;
      condArr[`QSR_GRP_MAR]  = condIn.measMargin;
      condArr[`QSR_GRP_IMP]  = condIn.measImprecise;
      maskArr[`QSR_GRP_COVL] = `QSR_MASK_COVL;
      maskArr[`QSR_GRP_ADC]  = `QSR_MASK_ADC;
      maskArr[`QSR_GRP_GOVL] = `QSR_MASK_GOVL;
      maskArr[`QSR_GRP_TEMP] = `QSR_MASK_TEMP;
      maskArr[`QSR_GRP_PSUP] = `QSR_MASK_PSUP;
      maskArr[`QSR_GRP_POVL] = `QSR_MASK_POVL;
      maskArr[`QSR_GRP_ALGN] = `QSR_MASK_ALGN;
      maskArr[`QSR_GRP_LIM]  = `QSR_MASK_MEASUREMENT_SOURCE;
      maskArr[`QSR_GRP_MAR]  = `QSR_MASK_MEASUREMENT_SOURCE;
      maskArr[`QSR_GRP_IMP]  = `QSR_MASK_MEASUREMENT_SOURCE;
   end

   // ===========================================================
   // APB decode
   assign setupPh  = apbReq.psel & ~apbReq.penable;
   assign accessPh = apbReq.psel & apbReq.penable;
   assign wrAcc    = accessPh & apbReq.pwrite;
   assign rdAcc    = accessPh & ~apbReq.pwrite;
   assign grpHit   = apbReq.paddr < `QSR_GRP_SPAN;
   assign grpIdx   = apbReq.paddr[`QSR_GRP_MSB:`QSR_GRP_LSB];
   assign wordIdx  = apbReq.paddr[`QSR_WRD_MSB:`QSR_WRD_LSB];
   assign selPart  = apbReq.pwdata[`QSR_SEL_PART_MSB:0];
   assign presetGo = wrAcc && apbReq.paddr == `QSR_ADDR_PRESET
                     && apbReq.pwdata[`QSR_PRESET_GO];
   assign listGrp  = apbReq.pwdata[3:0];
   assign listGrpOk = listGrp < 4'(`QSR_NGRP);
   assign viewGrp  = q.viewSel[`QSR_VSEL_GRP_LSB +: 4];
   assign viewGrpOk = viewGrp < 4'(`QSR_NGRP);
   assign viewIdx  = q.viewSel[`QSR_IDX_W-1:0];

   always_comb begin
      mapped = 1'b0;
      if (apbReq.paddr[1:0] == 2'h0) begin
         if (grpHit) begin
            mapped = wordIdx <= `QSR_WRD_SEL;
         end else begin
            case (apbReq.paddr)
               `QSR_ADDR_SUM, `QSR_ADDR_ISTAT, `QSR_ADDR_IMASK,
               `QSR_ADDR_PRESET, `QSR_ADDR_SUMENA, `QSR_ADDR_LSEL,
               `QSR_ADDR_LPOP, `QSR_ADDR_VSEL,
               `QSR_ADDR_VIEW: mapped = 1'b1;
               default: mapped = 1'b0;
            endcase
         end
      end
   end

   // Zero-wait slave; unmapped accesses error and read as zero
   assign pready  = 1'b1;
   assign pslverr = accessPh & ~mapped;
   assign prdata  = q.prdata;

   // NONE or ALL selector, else the literal mask
   assign selData = (wordIdx == `QSR_WRD_SEL)
                    ? (apbReq.pwdata[`QSR_SEL_ALL] ? `QSR_RST_ONES
                                                   : `QSR_RST_ZERO)
                    : apbReq.pwdata;

   // ===========================================================
   // Groups
   genvar g;
   generate
      for (g = 0; g < `QSR_NGRP; g++) begin : gen_grp
         logic hitG;
         assign hitG = wrAcc & grpHit & (grpIdx == 4'(g));
         assign wrEnaVec[g] = hitG & ((wordIdx == `QSR_WRD_ENA) |
            (wordIdx == `QSR_WRD_SEL && selPart == `QSR_PART_ENA));
         assign wrPtrVec[g] = hitG & ((wordIdx == `QSR_WRD_PTR) |
            (wordIdx == `QSR_WRD_SEL && selPart == `QSR_PART_PTR));
         assign wrNtrVec[g] = hitG & ((wordIdx == `QSR_WRD_NTR) |
            (wordIdx == `QSR_WRD_SEL && selPart == `QSR_PART_NTR));
         // Clear only what was reported, so later edges survive
         always_comb begin
            clrArr[g] = `QSR_RST_ZERO;
            if (rdAcc && grpHit && grpIdx == 4'(g)
                && wordIdx == `QSR_WRD_EVT) begin
               clrArr[g] = q.prdata;
            end
            if (wrAcc && apbReq.paddr == `QSR_ADDR_LSEL
                && apbReq.pwdata[`QSR_LSEL_EVT]
                && listGrp == 4'(g)) begin
               clrArr[g] = grpView[g].evt;
            end
         end
         qsr_group_cell u_cell (
            .core_clk  (core_clk),
            .rst_n     (rst_n),
            .condRaw   (condArr[g]),
            .validMask (maskArr[g]),
            .wrEna     (wrEnaVec[g]),
            .wrPtr     (wrPtrVec[g]),
            .wrNtr     (wrNtrVec[g]),
            .wrData    (selData),
            .evtClr    (clrArr[g]),
            .preset    (presetGo),
            .grp       (grpView[g]),
            .summary   (sumVec[g])
         );
         // Only quiet conditions: a new edge may legally re-set a bit
         a_cond_read_keeps: assert property (@(posedge core_clk)
            disable iff (!rst_n)
            (rdAcc && grpHit && grpIdx == 4'(g)
             && wordIdx == `QSR_WRD_COND && condIn == $past(condIn)
             && condIn == $past(condIn, 2) && condIn == $past(condIn, 3))
            |=> $stable(grpView[g].cond))
            else $error("condition changed by a read");
         a_evt_read_clears: assert property (@(posedge core_clk)
            disable iff (!rst_n)
            (rdAcc && grpHit && grpIdx == 4'(g) && !presetGo
             && wordIdx == `QSR_WRD_EVT && $stable(grpView[g].cond))
            |=> ((grpView[g].evt & $past(q.prdata)) == '0))
            else $error("reported events not cleared");
      end
   endgenerate

   // ===========================================================
   // Source list walk: lowest remaining source first
   always_comb begin
      popIdx   = '0;
      popValid = |q.listSnap;
      for (int i = 31; i >= 0; i--) begin
         if (q.listSnap[i]) begin
            popIdx = i[`QSR_IDX_W-1:0];
         end
      end
   end

   // ===========================================================
   // Read mux, sampled in the setup cycle
   always_comb begin
      rdVal = `QSR_RST_ZERO;
      if (grpHit) begin
         case (wordIdx)
            `QSR_WRD_COND: rdVal = grpView[grpIdx].cond;
            `QSR_WRD_EVT:  rdVal = grpView[grpIdx].evt;
            `QSR_WRD_ENA:  rdVal = grpView[grpIdx].ena;
            `QSR_WRD_PTR:  rdVal = grpView[grpIdx].ptr;
            `QSR_WRD_NTR:  rdVal = grpView[grpIdx].ntr;
            default:       rdVal = `QSR_RST_ZERO;
         endcase
      end else begin
         case (apbReq.paddr)
            `QSR_ADDR_SUM:    rdVal[`QSR_NGRP-1:0] = sumVec;
            `QSR_ADDR_ISTAT:  rdVal[`QSR_NGRP-1:0] = q.irqStat;
            `QSR_ADDR_IMASK:  rdVal[`QSR_NGRP-1:0] = q.irqMask;
            `QSR_ADDR_SUMENA: rdVal[`QSR_NGRP-1:0] = q.sumEna;
            `QSR_ADDR_VSEL:   rdVal[11:0] = q.viewSel;
            `QSR_ADDR_LPOP: begin
               rdVal[`QSR_LIST_VALID]  = popValid;
               rdVal[`QSR_IDX_W-1:0]   = popIdx;
            end
            `QSR_ADDR_VIEW: begin
               // Same flops as the group words, no private copy
               if (viewGrpOk) begin
                  rdVal[`QSR_VIEW_ENA]  = grpView[viewGrp].ena[viewIdx];
                  rdVal[`QSR_VIEW_EVT]  = grpView[viewGrp].evt[viewIdx];
                  rdVal[`QSR_VIEW_COND] = grpView[viewGrp].cond[viewIdx];
               end
            end
            default: rdVal = `QSR_RST_ZERO;
         endcase
      end
      if (!mapped) begin
         rdVal = `QSR_RST_ZERO;
      end
   end

   // ===========================================================
   // Bank state
   always_comb begin
      d = q;
      if (setupPh && !apbReq.pwrite) begin
         d.prdata = rdVal;
      end
      if (wrAcc) begin
         case (apbReq.paddr)
            `QSR_ADDR_ISTAT:
               d.irqStat = q.irqStat & ~apbReq.pwdata[`QSR_NGRP-1:0];
            `QSR_ADDR_IMASK:  d.irqMask = apbReq.pwdata[`QSR_NGRP-1:0];
            `QSR_ADDR_SUMENA: d.sumEna  = apbReq.pwdata[`QSR_NGRP-1:0];
            `QSR_ADDR_VSEL:   d.viewSel = apbReq.pwdata[11:0];
            `QSR_ADDR_LSEL: begin
               d.listSnap = `QSR_RST_ZERO;
               if (listGrpOk) begin
                  d.listSnap = apbReq.pwdata[`QSR_LSEL_EVT]
                               ? grpView[listGrp].evt
                               : grpView[listGrp].ena;
               end
            end
            default: d.sumEna = d.sumEna;
         endcase
      end
      if (rdAcc && apbReq.paddr == `QSR_ADDR_LPOP
          && q.prdata[`QSR_LIST_VALID]) begin
         d.listSnap[q.prdata[`QSR_IDX_W-1:0]] = 1'b0;
      end
      if (presetGo) begin
         d.sumEna = '0;
      end
      // Summary rise is the event upward; set wins over W1C
      d.irqStat = d.irqStat | (sumVec & ~q.sumPrev);
      d.sumPrev = sumVec;
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign questSummary = |(sumVec & q.sumEna);
   assign irq          = |(q.irqStat & q.irqMask);

   // ===========================================================
   // Checks
   // A bus write may legally clear or mask the flag one cycle later
   a_summary_rise_irq: assert property (@(posedge core_clk)
      disable iff (!rst_n)
      ((|(sumVec & ~$past(sumVec) & q.irqMask)) && !wrAcc) |=>
      irq ##1 (irq || $past(wrAcc)))
      else $error("summary rise did not interrupt");

   a_preset_sumena: assert property (@(posedge core_clk)
      disable iff (!rst_n) presetGo |=> (q.sumEna == '0 && !questSummary))
      else $error("preset kept top enables");

   // Writes leave prdata alone, so only reads must show zero
   a_unmapped_err: assert property (@(posedge core_clk)
      disable iff (!rst_n)
      (setupPh && !apbReq.pwrite && !mapped) ##1 accessPh |->
      (pslverr && prdata == '0))
      else $error("unmapped access not refused");

   c_evt_read:   cover property (@(posedge core_clk)
      rdAcc && grpHit && wordIdx == `QSR_WRD_EVT && q.prdata != '0);
   c_list_walk:  cover property (@(posedge core_clk)
      rdAcc && apbReq.paddr == `QSR_ADDR_LPOP && q.prdata != '0);
   c_irq:        cover property (@(posedge core_clk) $rose(irq));
   c_preset:     cover property (@(posedge core_clk) presetGo);

endmodule : qsr_status_bank

// ===== dv/tb.sv
// Bench for the questionable status bank: APB tasks, random conditions.
// Assumes qsr_pkg and qsr_defines.svh compiled first.
`timescale 1ns/1ps
`include "qsr_defines.svh"

module tb;
   logic                 core_clk;
   logic                 rst_n;
   qsr_pkg::qsr_apb_req_t apbReq;
   qsr_pkg::qsr_cond_t   condIn;
   logic [31:0]          prdata;
   logic                 pready;
   logic                 pslverr;
   logic                 questSummary;
   logic                 irq;
   logic                 lastErr;
   logic [31:0]          rdv;
   logic [31:0]          seed;
   int                   num_errors;
   int                   checks;

   qsr_status_bank qsr_status_bank_i (
      .core_clk     (core_clk),
      .rst_n        (rst_n),
      .apbReq       (apbReq),
      .prdata       (prdata),
      .pready       (pready),
      .pslverr      (pslverr),
      .condIn       (condIn),
      .questSummary (questSummary),
      .irq          (irq)
   );

   // ===========================================================
   // Helpers
   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd

   function automatic logic [11:0] ad(input int g, input int w);
      return 12'(g * 32 + w * 4);
   endfunction : ad

   task automatic results();
      $display("errors %0d checks %0d", num_errors, checks);
      if (num_errors == 0 && checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : results

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   // Entered just after a rising edge; one idle cycle between transfers
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      int n;
      @(posedge core_clk);
      apbReq <= '{paddr: a, pwrite: w, pwdata: d, psel: 1'b1,
                  penable: 1'b0};
      @(posedge core_clk);
      apbReq.penable <= 1'b1;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         num_errors++;
         results();
      end
      rdv = prdata;
      lastErr = pslverr;
      apbReq.psel <= 1'b0;
      apbReq.penable <= 1'b0;
   endtask : apb

   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rdv, exp);
   endtask : rd

   // ===========================================================
   // Main sequence
   initial begin
      apbReq = '0;
      condIn = '0;
      rst_n = 1'b0;
      seed = 32'h56;
      num_errors = 0;
      checks = 0;
      repeat (16) @(posedge core_clk);
      rst_n <= 1'b1;
      rd(ad(3, 2), 32'h0);
      rd(ad(3, 3), `QSR_MASK_TEMP);
      rd(ad(3, 4), 32'h0);
      apb(1'b1, `QSR_ADDR_IMASK, 32'h8);
      apb(1'b1, `QSR_ADDR_SUMENA, 32'h8);
      apb(1'b1, ad(3, 2), 32'h1);
      condIn.thermal <= 32'h3;
      repeat (6) @(posedge core_clk);
      rd(ad(3, 0), 32'h3);
      rd(ad(3, 0), 32'h3);
      rd(`QSR_ADDR_SUM, 32'h8);
      chk({31'h0, questSummary}, 32'h1);
      chk({31'h0, irq}, 32'h1);
      rd(ad(3, 1), 32'h3);
      rd(ad(3, 1), 32'h0);
      rd(`QSR_ADDR_ISTAT, 32'h8);
      apb(1'b1, `QSR_ADDR_ISTAT, 32'h8);
      rd(`QSR_ADDR_ISTAT, 32'h0);
      chk({31'h0, irq}, 32'h0);
      // Falling filter only on the error source
      apb(1'b1, ad(3, 4), 32'h2);
      condIn.thermal <= 32'h1;
      repeat (6) @(posedge core_clk);
      rd(ad(3, 1), 32'h2);
      apb(1'b1, ad(1, 5), 32'h11);
      rd(ad(1, 2), `QSR_MASK_ADC);
      apb(1'b1, ad(1, 5), 32'h01);
      rd(ad(1, 2), 32'h0);
      apb(1'b1, ad(3, 5), 32'h11);
      apb(1'b1, `QSR_ADDR_LSEL, 32'h3);
      rd(`QSR_ADDR_LPOP, 32'h8000_0000);
      rd(`QSR_ADDR_LPOP, 32'h8000_0001);
      rd(`QSR_ADDR_LPOP, 32'h0);
      apb(1'b1, `QSR_ADDR_VSEL, 32'h300);
      rd(`QSR_ADDR_VIEW, 32'h5);
      // Random condition words; bits outside each mask must stay 0
      repeat (4) begin
         condIn.channelOverload <= rnd();
         condIn.converterClip <= ~seed;
         condIn.measLimit <= seed;
         repeat (6) @(posedge core_clk);
         rd(ad(0, 0), seed & `QSR_MASK_COVL);
         rd(ad(1, 0), ~seed);
         rd(ad(7, 0), seed & `QSR_MASK_MEASUREMENT_SOURCE);
      end
      apb(1'b1, `QSR_ADDR_PRESET, 32'h1);
      rd(ad(3, 3), `QSR_MASK_TEMP);
      rd(ad(3, 4), 32'h0);
      rd(ad(0, 1), 32'h0);
      rd(`QSR_ADDR_SUMENA, 32'h0);
      rd(12'h1FC, 32'h0);
      chk({31'h0, lastErr}, 32'h1);
      results();
   end
endmodule : tb
